// [inc/monitor_alarm_map.svh]
/*
  Register offsets, field positions, reset values and counts of the monitor alarm flag unit.
  Assumes byte-wide registers on two register pages picked by a page bit.
*/
`ifndef MONITOR_ALARM_MAP_SVH
`define MONITOR_ALARM_MAP_SVH

`define MAF_PAGE_DIAG 1'b0
`define MAF_PAGE_MAKER 1'b1

// Diagnostic page
`define MAF_ALM_STAT_HI 8'h70
`define MAF_ALM_STAT_LO 8'h71
`define MAF_WRN_STAT_HI 8'h74
`define MAF_WRN_STAT_LO 8'h75
`define MAF_ALM_MASK_MAIN 8'hf8
`define MAF_ALM_MASK_RX 8'hf9
`define MAF_WRN_MASK_MAIN 8'hfa
`define MAF_WRN_MASK_RX 8'hfb

// Maker page
`define MAF_CFG_ZERO 8'h05
`define MAF_CFG_FOUR 8'h19
`define MAF_DATA_READY 8'hfd

`define MAF_MASK_MAIN_RST 8'h00
`define MAF_MASK_RX_RST 8'h40
`define MAF_MASK_RX_WMASK 8'hc0
`define MAF_CFG_ZERO_RST 8'h00
`define MAF_CFG_FOUR_RST 8'h00

`define MAF_CFG0_AUX_LSB 0
`define MAF_CFG0_TEMP9_BIT 3
`define MAF_CFG0_MAKER_BIT 7
`define MAF_CFG4_ALM_LIVE_BIT 4
`define MAF_CFG4_WRN_LIVE_BIT 5
`define MAF_CFG4_ALM_FAULT_BIT 6
`define MAF_CFG4_WRN_FAULT_BIT 7

`define MAF_NUM_CHAN 5
`define MAF_NUM_FLAGS 10

`endif

// [inc/monitor_alarm_pkg.sv]
/*
  Types shared by the monitor alarm flag unit and its conversion sequencer.
  Assumes the map header supplies the numeric constants.
*/
package monitor_alarm_pkg;

  typedef enum logic [2:0] {
    CH_TEMP,
    CH_AUX,
    CH_MPD,
    CH_ILD,
    CH_RX
  } chan_t;

  typedef enum logic [2:0] {
    AUX_SUPPLY,
    AUX_ANALOG_SUPPLY,
    AUX_BIAS_NODE,
    AUX_MOD_NODE,
    AUX_POWER_LOOP_DAC,
    AUX_MOD_DAC,
    AUX_FAULT_DAC,
    AUX_RESERVED
  } aux_sel_t;

  // Byte access from the serial interface engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [8:0] temp;
    logic [7:0] aux;
    logic [7:0] mpd;
    logic [7:0] ild;
    logic [11:0] rx;
  } results_t;

endpackage : monitor_alarm_pkg

// [rtl/conv_sequencer.sv]
/*
  Round-robin converter sequencer: starts one conversion per channel, in fixed order.
  Assumes the converter answers each start with exactly one done pulse.
*/
`timescale 1ns/1ps
module conv_sequencer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic convDone,
  output logic convStart,
  output monitor_alarm_pkg::chan_t convChan,
  output logic capture
);
  import monitor_alarm_pkg::*;

  typedef enum logic {SEQ_START, SEQ_WAIT} seq_state_t;

  seq_state_t state_ff;
  seq_state_t nxt_state;
  chan_t chan_ff;
  chan_t nxt_chan;
  wire logic lastChan = (chan_ff == CH_RX);

  assign convStart = (state_ff == SEQ_START);
  assign capture = (state_ff == SEQ_WAIT) && convDone;
  assign convChan = chan_ff;
  assign nxt_state = convStart ? SEQ_WAIT : (capture ? SEQ_START : state_ff);
  assign nxt_chan = !capture ? chan_ff : (lastChan ? CH_TEMP : chan_t'(chan_ff + 3'd1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SEQ_START;
      chan_ff <= CH_TEMP;
    end else if (ce) begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
    end
  end

  property p_wrap;
    @(posedge clk_sys) disable iff (!rstn)
      (ce && capture && lastChan) |=> (convChan == CH_TEMP);
  endproperty
  a_wrap: assert property (p_wrap) else $error("sequence did not wrap to temperature");

  property p_step;
    @(posedge clk_sys) disable iff (!rstn)
      (ce && capture && !lastChan) |=> (convChan == chan_t'($past(convChan) + 3'd1));
  endproperty
  a_step: assert property (p_step) else $error("sequence skipped a channel");

endmodule : conv_sequencer

// [rtl/monitor_alarm_flag_unit.sv]
/*
  Monitor alarm flag unit: sequences the converter, keeps results, alarm and
  warning flags, masks, interrupt and transmit-fault outputs.
  Assumes a serial interface engine delivers one-cycle byte read/write strobes
  and that threshold comparators deliver live condition bits.
*/
// How it works
// - Convert five channels in fixed round-robin order
// - Maker mode lets aux channel pick other nodes
// - Three-bit select chooses auxiliary input source
// - Result widths: temp 8/9, others 8, rx 12
// - Violation sets flag, raises unmasked interrupt
// - Mask bit one blocks interrupt, flag still sets
// - Byte F8 alarm masks, all reset zero
// - Byte F9 rx alarm masks, low resets one
// - Byte FA warning masks, same order, zero
// - Byte FB rx warning masks, low resets one
// - Config four bit 6 routes alarms to fault
// - Config four bit 7 routes warnings to fault
// - Same masks suppress each transmit-fault source
// - Flags latch until read or disable toggles
// - Config four bit 5 makes warnings live
// - Config four bit 4 makes alarms live
// - Read-only data-ready byte, one bit per channel
`timescale 1ns/1ps
`include "monitor_alarm_map.svh"
module monitor_alarm_flag_unit (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input monitor_alarm_pkg::reg_req_t regReq,
  output logic [7:0] regRdData,
  input wire logic convDone,
  input wire logic [11:0] convData,
  output logic convStart,
  output monitor_alarm_pkg::chan_t convChan,
  output monitor_alarm_pkg::aux_sel_t auxSelect,
  output monitor_alarm_pkg::results_t results,
  input wire logic [9:0] alarmCond,
  input wire logic [9:0] warnCond,
  input wire logic transmitDisableIn,
  output logic irqOut,
  output logic transmitFaultOut
);
  import monitor_alarm_pkg::*;

  logic [7:0] almMaskMain_ff;
  logic [7:0] almMaskRx_ff;
  logic [7:0] wrnMaskMain_ff;
  logic [7:0] wrnMaskRx_ff;
  logic [7:0] cfgZero_ff;
  logic [7:0] cfgFour_ff;
  logic [9:0] alarmFlags_ff;
  logic [9:0] warnFlags_ff;
  logic [9:0] nxt_alarmFlags;
  logic [9:0] nxt_warnFlags;
  logic [9:0] alarmCondPrev_ff;
  logic [9:0] warnCondPrev_ff;
  logic [4:0] dataReady_ff;
  logic txDisPrev_ff;
  logic irq_ff;
  logic fault_ff;
  logic [7:0] rdData_ff;
  results_t results_ff;
  logic capture;

  conv_sequencer u_seq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .convDone(convDone),
    .convStart(convStart),
    .convChan(convChan),
    .capture(capture)
  );

  // Register decode
  wire logic onDiag = (regReq.page == `MAF_PAGE_DIAG);
  wire logic onMaker = (regReq.page == `MAF_PAGE_MAKER);
  wire logic wrAlmMain = regReq.wr && onDiag && (regReq.addr == `MAF_ALM_MASK_MAIN);
  wire logic wrAlmRx = regReq.wr && onDiag && (regReq.addr == `MAF_ALM_MASK_RX);
  wire logic wrWrnMain = regReq.wr && onDiag && (regReq.addr == `MAF_WRN_MASK_MAIN);
  wire logic wrWrnRx = regReq.wr && onDiag && (regReq.addr == `MAF_WRN_MASK_RX);
  wire logic wrCfgZero = regReq.wr && onMaker && (regReq.addr == `MAF_CFG_ZERO);
  wire logic wrCfgFour = regReq.wr && onMaker && (regReq.addr == `MAF_CFG_FOUR);
  wire logic rdAlmHi = regReq.rd && onDiag && (regReq.addr == `MAF_ALM_STAT_HI);
  wire logic rdAlmLo = regReq.rd && onDiag && (regReq.addr == `MAF_ALM_STAT_LO);
  wire logic rdWrnHi = regReq.rd && onDiag && (regReq.addr == `MAF_WRN_STAT_HI);
  wire logic rdWrnLo = regReq.rd && onDiag && (regReq.addr == `MAF_WRN_STAT_LO);
  wire logic rdReady = regReq.rd && onMaker && (regReq.addr == `MAF_DATA_READY);

  // Configuration fields
  wire logic makerMode = cfgZero_ff[`MAF_CFG0_MAKER_BIT];
  wire logic tempNine = cfgZero_ff[`MAF_CFG0_TEMP9_BIT];
  wire logic [2:0] auxField = cfgZero_ff[`MAF_CFG0_AUX_LSB +: 3];
  wire logic alarmLive = cfgFour_ff[`MAF_CFG4_ALM_LIVE_BIT];
  wire logic warnLive = cfgFour_ff[`MAF_CFG4_WRN_LIVE_BIT];
  wire logic alarmToFault = cfgFour_ff[`MAF_CFG4_ALM_FAULT_BIT];
  wire logic warnToFault = cfgFour_ff[`MAF_CFG4_WRN_FAULT_BIT];

  // Outside maker mode the aux channel always measures the supply input
  assign auxSelect = (!makerMode || auxField == 3'b111) ? AUX_SUPPLY
                                                        : aux_sel_t'(auxField);

  // Flag vector order: bits 9..2 follow the main mask byte, 1 = rx high, 0 = rx low
  wire logic [9:0] alarmMaskVec = {almMaskMain_ff, almMaskRx_ff[7:6]};
  wire logic [9:0] warnMaskVec = {wrnMaskMain_ff, wrnMaskRx_ff[7:6]};
  wire logic [9:0] alarmUnmasked = alarmFlags_ff & ~alarmMaskVec;
  wire logic [9:0] warnUnmasked = warnFlags_ff & ~warnMaskVec;
  wire logic nxt_irq = (|alarmUnmasked) || (|warnUnmasked);
  wire logic nxt_fault = (alarmToFault && |alarmUnmasked) || (warnToFault && |warnUnmasked);

  // Any edge of the disable pin clears every flag
  wire logic txToggle = transmitDisableIn ^ txDisPrev_ff;
  wire logic [9:0] alarmClr = {{8{rdAlmHi}}, {2{rdAlmLo}}} | {10{txToggle}};
  wire logic [9:0] warnClr = {{8{rdWrnHi}}, {2{rdWrnLo}}} | {10{txToggle}};

  // A live flag sets on the condition's rising edge, so a clear cannot hide a new event
  genvar i;
  generate
    for (i = 0; i < `MAF_NUM_FLAGS; i++) begin : g_flag
      assign nxt_alarmFlags[i] = alarmLive
        ? (alarmCond[i] && ((alarmFlags_ff[i] && !alarmClr[i]) || !alarmCondPrev_ff[i]))
        : ((alarmFlags_ff[i] && !alarmClr[i]) || alarmCond[i]);
      assign nxt_warnFlags[i] = warnLive
        ? (warnCond[i] && ((warnFlags_ff[i] && !warnClr[i]) || !warnCondPrev_ff[i]))
        : ((warnFlags_ff[i] && !warnClr[i]) || warnCond[i]);
    end
  endgenerate

  // Data-ready: set by a captured result, cleared by reading, set wins
  wire logic [4:0] readySet = capture ? (5'b00001 << convChan) : 5'b00000;
  wire logic [4:0] nxt_dataReady = (rdReady ? 5'b00000 : dataReady_ff) | readySet;

  // Temperature keeps its ninth bit only in nine-bit mode
  wire logic [8:0] tempRes = tempNine ? convData[11:3] : {convData[11:4], 1'b0};

  wire logic [7:0] rdMux =
    rdAlmHi ? alarmFlags_ff[9:2] :
    rdAlmLo ? {alarmFlags_ff[1:0], 6'h00} :
    rdWrnHi ? warnFlags_ff[9:2] :
    rdWrnLo ? {warnFlags_ff[1:0], 6'h00} :
    rdReady ? {3'b000, dataReady_ff} :
    (onDiag && regReq.addr == `MAF_ALM_MASK_MAIN) ? almMaskMain_ff :
    (onDiag && regReq.addr == `MAF_ALM_MASK_RX) ? almMaskRx_ff :
    (onDiag && regReq.addr == `MAF_WRN_MASK_MAIN) ? wrnMaskMain_ff :
    (onDiag && regReq.addr == `MAF_WRN_MASK_RX) ? wrnMaskRx_ff :
    (onMaker && regReq.addr == `MAF_CFG_ZERO) ? cfgZero_ff :
    (onMaker && regReq.addr == `MAF_CFG_FOUR) ? cfgFour_ff : 8'h00;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      almMaskMain_ff <= `MAF_MASK_MAIN_RST;
      almMaskRx_ff <= `MAF_MASK_RX_RST;
      wrnMaskMain_ff <= `MAF_MASK_MAIN_RST;
      wrnMaskRx_ff <= `MAF_MASK_RX_RST;
      cfgZero_ff <= `MAF_CFG_ZERO_RST;
      cfgFour_ff <= `MAF_CFG_FOUR_RST;
    end else if (ce) begin
      if (wrAlmMain) almMaskMain_ff <= regReq.wdata;
      if (wrAlmRx) almMaskRx_ff <= regReq.wdata & `MAF_MASK_RX_WMASK;
      if (wrWrnMain) wrnMaskMain_ff <= regReq.wdata;
      if (wrWrnRx) wrnMaskRx_ff <= regReq.wdata & `MAF_MASK_RX_WMASK;
      if (wrCfgZero) cfgZero_ff <= regReq.wdata;
      if (wrCfgFour) cfgFour_ff <= regReq.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      alarmFlags_ff <= 10'h000;
      warnFlags_ff <= 10'h000;
      alarmCondPrev_ff <= 10'h000;
      warnCondPrev_ff <= 10'h000;
      txDisPrev_ff <= 1'b0;
      dataReady_ff <= 5'h00;
      irq_ff <= 1'b0;
      fault_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end else if (ce) begin
      alarmFlags_ff <= nxt_alarmFlags;
      warnFlags_ff <= nxt_warnFlags;
      alarmCondPrev_ff <= alarmCond;
      warnCondPrev_ff <= warnCond;
      txDisPrev_ff <= transmitDisableIn;
      dataReady_ff <= nxt_dataReady;
      irq_ff <= nxt_irq;
      fault_ff <= nxt_fault;
      if (regReq.rd) rdData_ff <= rdMux;
    end
  end

  // Results are refreshed one channel at a time as conversions complete
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      results_ff <= '0;
    end else if (ce && capture) begin
      unique case (convChan)
        CH_TEMP: results_ff.temp <= tempRes;
        CH_AUX: results_ff.aux <= convData[11:4];
        CH_MPD: results_ff.mpd <= convData[11:4];
        CH_ILD: results_ff.ild <= convData[11:4];
        CH_RX: results_ff.rx <= convData;
        default: results_ff <= results_ff;
      endcase
    end
  end

  assign results = results_ff;
  assign regRdData = rdData_ff;
  assign irqOut = irq_ff;
  assign transmitFaultOut = fault_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_irq_set;
    ce && alarmCond[9] && !alarmMaskVec[9] && !alarmLive ##1 ce |=> irqOut;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("unmasked alarm gave no interrupt");

  property p_mask_quiet;
    (ce && alarmUnmasked == 10'h000 && warnUnmasked == 10'h000) |=> !irqOut;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked source raised interrupt");

  property p_flag_sets;
    (ce && !alarmLive && alarmCond[0]) |=> alarmFlags_ff[0];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("alarm flag not set");

  property p_latch_hold;
    (ce && !alarmLive && alarmFlags_ff[9] && !rdAlmHi && !txToggle) |=> alarmFlags_ff[9];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped");

  property p_read_clears;
    (ce && !warnLive && rdWrnHi && !txToggle && !warnCond[5]) |=> !warnFlags_ff[5];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read left warning set");

  property p_fault_default;
    (ce && !alarmToFault && !warnToFault) |=> !transmitFaultOut;
  endproperty
  a_fault_default: assert property (p_fault_default) else $error("fault without source");

  property p_fault_warn;
    (ce && warnToFault && |warnUnmasked) |=> transmitFaultOut;
  endproperty
  a_fault_warn: assert property (p_fault_warn) else $error("warning fault missing");

  property p_warn_live;
    (ce && warnLive && !warnCond[3]) |=> !warnFlags_ff[3];
  endproperty
  a_warn_live: assert property (p_warn_live) else $error("live warning stuck");

  property p_alarm_live;
    (ce && alarmLive && !alarmCond[2]) |=> !alarmFlags_ff[2];
  endproperty
  a_alarm_live: assert property (p_alarm_live) else $error("live alarm stuck");

  property p_aux_sel;
    (!makerMode || auxField == 3'b111) |-> (auxSelect == AUX_SUPPLY);
  endproperty
  a_aux_sel: assert property (p_aux_sel) else $error("aux select not supply");

  property p_ready;
    (ce && capture) |=> dataReady_ff[$past(convChan)];
  endproperty
  a_ready: assert property (p_ready) else $error("data ready not set");

  property p_irq_warn;
    (ce && |warnUnmasked) |=> irqOut;
  endproperty
  a_irq_warn: assert property (p_irq_warn) else $error("unmasked warning gave no interrupt");

  property p_fault_alarm;
    (ce && alarmToFault && |alarmUnmasked) |=> transmitFaultOut;
  endproperty
  a_fault_alarm: assert property (p_fault_alarm) else $error("alarm fault missing");

  property p_toggle_clears;
    (ce && txToggle && alarmCond == 10'h000) |=> (alarmFlags_ff == 10'h000);
  endproperty
  a_toggle_clears: assert property (p_toggle_clears) else $error("toggle left alarm set");

  property p_rx_reserved;
    ce |-> (almMaskRx_ff[5:0] == 6'h00) && (wrnMaskRx_ff[5:0] == 6'h00);
  endproperty
  a_rx_reserved: assert property (p_rx_reserved) else $error("reserved mask bits set");

  // Nine-bit mode keeps one more result bit than the eight-bit path
  property p_temp_nine;
    (ce && capture && convChan == CH_TEMP && tempNine)
      |=> (results.temp == $past(convData[11:3]));
  endproperty
  a_temp_nine: assert property (p_temp_nine) else $error("nine-bit temperature wrong");

  property p_results_hold;
    (!ce || !capture) |=> $stable(results);
  endproperty
  a_results_hold: assert property (p_results_hold) else $error("result moved without capture");

  c_irq: cover property (ce && !irqOut ##1 irqOut);
  c_fault: cover property (ce && alarmToFault ##1 transmitFaultOut);
  c_toggle_clear: cover property (ce && txToggle && |alarmFlags_ff);
  c_full_round: cover property (ce && capture && convChan == CH_RX);

endmodule : monitor_alarm_flag_unit

// [sim/conv_model.sv]
/*
  Behavioural converter facing the flag unit: one done pulse for each start.
  Assumes the bench supplies the next result word and a latency in cycles.
*/
`timescale 1ns/1ps
module conv_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic convStart,
  input wire logic [11:0] nextData,
  input wire logic [3:0] latency,
  output logic convDone,
  output logic [11:0] convData
);
  logic busy;
  logic [3:0] cnt;
  initial begin
    convDone = 1'b0;
    convData = 12'h0a5a;
  end
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      convDone <= 1'b0;
    end else if (ce) begin
      // Shares the system clock enable, so a frozen unit never misses a done pulse
      convDone <= 1'b0;
      // Data means something only in the done cycle, so it wanders otherwise
      convData <= ~convData;
      if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        convDone <= 1'b1;
        convData <= nextData;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end else if (convStart) begin
        busy <= 1'b1;
        cnt <= latency;
      end
    end
  end
endmodule : conv_model

// [sim/monitor_alarm_flag_unit_tb.sv]
/*
  Self-checking bench for the monitor alarm flag unit with a converter model.
  Assumes the map header and package of the design; reads are checked from a queue.
*/
`timescale 1ns/1ps
`include "monitor_alarm_map.svh"
module monitor_alarm_flag_unit_tb;
  import monitor_alarm_pkg::*;
  localparam logic pgDiag = `MAF_PAGE_DIAG;
  localparam logic pgMaker = `MAF_PAGE_MAKER;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  reg_req_t regReq = '0;
  logic [7:0] regRdData;
  logic convDone, convStart, irqOut, transmitFaultOut;
  logic [11:0] convData, dataSeen;
  logic [11:0] nextData = 12'h0000;
  logic [3:0] latency = 4'h0;
  chan_t convChan, chanSeen;
  aux_sel_t auxSelect;
  results_t results;
  logic [9:0] alarmCond = 10'h000;
  logic [9:0] warnCond = 10'h000;
  logic transmitDisableIn = 1'b0;
  logic rdTaken = 1'b0;
  logic doneSeen = 1'b0;
  logic ce = 1'b1;
  logic nineMode = 1'b0;
  logic nineSeen = 1'b0;
  logic [7:0] expQ[$];
  int errCount = 0;
  int samplesChecked = 0;
  int seed = 30986;
  int expChan = 0;

  always #5 clk_sys = ~clk_sys;

  monitor_alarm_flag_unit dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .regReq(regReq),
    .regRdData(regRdData), .convDone(convDone), .convData(convData), .convStart(convStart),
    .convChan(convChan), .auxSelect(auxSelect), .results(results), .alarmCond(alarmCond),
    .warnCond(warnCond), .transmitDisableIn(transmitDisableIn), .irqOut(irqOut),
    .transmitFaultOut(transmitFaultOut));
  conv_model conv_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .convStart(convStart),
    .nextData(nextData), .latency(latency), .convDone(convDone), .convData(convData));

  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
    check({4'h0, got}, {4'h0, exp}, "read byte");
  endtask : check_read

  task automatic check_pin(input logic got, input logic exp, input string what);
    check({11'h000, got}, {11'h000, exp}, what);
  endtask : check_pin

  task automatic report_and_stop;
    if (expQ.size() != 0) begin
      errCount++;
      $display("BAD t=%0t reads left unanswered", $time);
    end
    $display("checked %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // Strobes drop and one edge passes, so back-to-back calls never re-raise in one step
  task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
    regReq = '{1'b1, 1'b0, pg, a, d};
    tick(1);
    regReq.wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic pg, input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regReq = '{1'b0, 1'b1, pg, a, 8'h00};
    tick(1);
    regReq.rd = 1'b0;
    tick(1);
  endtask : rd

  task automatic pulse(input logic [9:0] a, input logic [9:0] w);
    alarmCond = a;
    warnCond = w;
    tick(1);
    alarmCond = 10'h000;
    warnCond = 10'h000;
    tick(2);
  endtask : pulse

  always @(posedge clk_sys) begin
    rdTaken <= regReq.rd & rstn & ce;
    doneSeen <= convDone & rstn & ce;
    // Reference copy of the nine-bit temperature mode, as the unit sees it at this edge
    if (ce && rstn && regReq.wr && regReq.page == pgMaker && regReq.addr == `MAF_CFG_ZERO) begin
      nineMode <= regReq.wdata[`MAF_CFG0_TEMP9_BIT];
    end
    nineSeen <= nineMode;
    dataSeen <= convData;
    chanSeen <= convChan;
  end

  always @(negedge clk_sys) begin
    if (rdTaken && expQ.size() == 0) check(12'h000, 12'hfff, "read not expected");
    else if (rdTaken) check_read(regRdData, expQ.pop_front());
    if (doneSeen) begin
      check({9'h000, chanSeen}, 12'(expChan), "channel order");
      case (chanSeen)
        CH_TEMP: check({3'h0, results.temp},
          nineSeen ? {3'h0, dataSeen[11:3]} : {3'h0, dataSeen[11:4], 1'b0}, "temp");
        CH_AUX: check({4'h0, results.aux}, {4'h0, dataSeen[11:4]}, "aux");
        CH_MPD: check({4'h0, results.mpd}, {4'h0, dataSeen[11:4]}, "mpd");
        CH_ILD: check({4'h0, results.ild}, {4'h0, dataSeen[11:4]}, "ild");
        default: check(results.rx, dataSeen, "rx");
      endcase
      expChan = (expChan + 1) % 5;
      latency <= 4'($random(seed));
    end
    nextData <= 12'($random(seed));
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    errCount++;
    $display("BAD t=%0t run did not finish", $time);
    report_and_stop;
  end

  initial begin
    logic [9:0] bits;
    logic [9:0] flags;
    logic [2:0] auxExp;
    tick(2);
    rstn = 1'b1;
    rd(pgDiag, `MAF_ALM_MASK_MAIN, 8'h00);
    rd(pgDiag, `MAF_ALM_MASK_RX, 8'h40);
    rd(pgDiag, `MAF_WRN_MASK_MAIN, 8'h00);
    rd(pgDiag, `MAF_WRN_MASK_RX, 8'h40);
    wr(pgDiag, `MAF_ALM_MASK_RX, 8'hff);
    rd(pgDiag, `MAF_ALM_MASK_RX, 8'hc0);
    wr(pgDiag, `MAF_WRN_MASK_RX, 8'h3f);
    rd(pgDiag, `MAF_WRN_MASK_RX, 8'h00);
    wr(pgDiag, 8'h80, 8'h5a);
    rd(pgDiag, 8'h80, 8'h00);
    $display("test register access finished");
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 10; i++) begin
        for (int m = 0; m < 2; m++) begin
          bits = m ? 10'h001 << i : 10'h000;
          flags = 10'h001 << i;
          wr(pgDiag, k ? `MAF_WRN_MASK_MAIN : `MAF_ALM_MASK_MAIN, bits[9:2]);
          wr(pgDiag, k ? `MAF_WRN_MASK_RX : `MAF_ALM_MASK_RX, {bits[1:0], 6'h00});
          pulse(k ? 10'h000 : flags, k ? flags : 10'h000);
          check_pin(irqOut, ~m[0], "irq per source");
          rd(pgDiag, k ? `MAF_WRN_STAT_HI : `MAF_ALM_STAT_HI, flags[9:2]);
          rd(pgDiag, k ? `MAF_WRN_STAT_LO : `MAF_ALM_STAT_LO, {flags[1:0], 6'h00});
          check_pin(irqOut, 1'b0, "irq after read");
        end
      end
    end
    $display("test masks and latching finished");
    for (int c = 0; c < 4; c++) begin
      wr(pgMaker, `MAF_CFG_FOUR, {c[1], c[0], 6'h00});
      pulse(10'h004, 10'h000);
      check_pin(transmitFaultOut, c[0], "alarm fault route");
      rd(pgDiag, `MAF_ALM_STAT_HI, 8'h01);
      pulse(10'h000, 10'h008);
      check_pin(transmitFaultOut, c[1], "warning fault route");
      rd(pgDiag, `MAF_WRN_STAT_HI, 8'h02);
    end
    wr(pgDiag, `MAF_ALM_MASK_MAIN, 8'h01);
    pulse(10'h004, 10'h000);
    check_pin(transmitFaultOut, 1'b0, "masked fault");
    check_pin(irqOut, 1'b0, "masked irq");
    rd(pgDiag, `MAF_ALM_STAT_HI, 8'h01);
    pulse(10'h200, 10'h000);
    check_pin(transmitFaultOut, 1'b1, "fault before toggle");
    transmitDisableIn = 1'b1;
    tick(3);
    check_pin(transmitFaultOut, 1'b0, "fault after toggle");
    rd(pgDiag, `MAF_ALM_STAT_HI, 8'h00);
    $display("test fault routing finished");
    for (int k = 0; k < 2; k++) begin
      wr(pgMaker, `MAF_CFG_FOUR, k ? 8'h20 : 8'h10);
      alarmCond = k ? 10'h000 : 10'h100;
      warnCond = k ? 10'h100 : 10'h000;
      tick(3);
      rd(pgDiag, k ? `MAF_WRN_STAT_HI : `MAF_ALM_STAT_HI, 8'h40);
      alarmCond = 10'h000;
      warnCond = 10'h000;
      // Let the condition fall first, so the pulse is a fresh rising edge
      tick(1);
      pulse(k ? 10'h000 : 10'h100, k ? 10'h100 : 10'h000);
      rd(pgDiag, k ? `MAF_WRN_STAT_HI : `MAF_ALM_STAT_HI, 8'h00);
    end
    wr(pgMaker, `MAF_CFG_FOUR, 8'h00);
    alarmCond = 10'h200;
    tick(2);
    rd(pgDiag, `MAF_ALM_STAT_HI, 8'h80);
    rd(pgDiag, `MAF_ALM_STAT_HI, 8'h80);
    alarmCond = 10'h000;
    rd(pgDiag, `MAF_ALM_STAT_HI, 8'h80);
    rd(pgDiag, `MAF_ALM_STAT_HI, 8'h00);
    $display("test live flags finished");
    for (int c = 0; c < 16; c++) begin
      wr(pgMaker, `MAF_CFG_ZERO, {c[3], 4'h0, c[2:0]});
      auxExp = (c[3] && c[2:0] != 3'h7) ? c[2:0] : 3'h0;
      check({9'h000, auxSelect}, {9'h000, auxExp}, "aux source");
    end
    wr(pgMaker, `MAF_CFG_ZERO, 8'h08);
    tick(200);
    wr(pgMaker, `MAF_CFG_ZERO, 8'h00);
    wr(pgMaker, `MAF_DATA_READY, 8'h00);
    tick(100);
    rd(pgMaker, `MAF_DATA_READY, 8'h1f);
    $display("test aux select and data ready finished");
    ce = 1'b0;
    wr(pgDiag, `MAF_ALM_MASK_MAIN, 8'h3c);
    pulse(10'h200, 10'h000);
    ce = 1'b1;
    rd(pgDiag, `MAF_ALM_MASK_MAIN, 8'h01);
    rd(pgDiag, `MAF_ALM_STAT_HI, 8'h00);
    $display("test clock enable finished");
    tick(4);
    report_and_stop;
  end
endmodule : monitor_alarm_flag_unit_tb
